// File: hdl/absd_pkg.sv
// Constants shared by the analog bus strobe decode block.
// Assumes a 100 MHz system clock and a 1 MHz timing clock.
package absd_pkg;

  // Delay from analog bus request to demultiplexer enable
  localparam int ABSD_DELAY_US = 2;
  localparam int ABSD_TIMING_MHZ = 1;
  localparam logic [1:0] ABSD_DELAY_TICKS =
    2'(ABSD_DELAY_US * ABSD_TIMING_MHZ);
  localparam logic [1:0] ABSD_CNT_RST = 2'h0;

  // Analog bus unit codes, also strobe bank positions
  localparam logic [1:0] ABSD_UNIT_RF = 2'h0;
  localparam logic [1:0] ABSD_UNIT_FC = 2'h1;
  localparam logic [1:0] ABSD_UNIT_IF = 2'h2;
  localparam logic [1:0] ABSD_UNIT_LOG = 2'h3;

  // First local decoder line positions
  localparam int ABSD_L1_KBD_SCAN = 0;
  localparam int ABSD_L1_DAC_UPD = 1;
  localparam int ABSD_L1_DAC_ONE = 2;
  localparam int ABSD_L1_DAC_TWO = 3;
  localparam int ABSD_L1_DAC_THREE = 4;
  localparam int ABSD_L1_TIMER = 6;
  localparam int ABSD_L1_CONV_REG1 = 7;

  // Second local decoder line positions
  localparam int ABSD_L2_KBD_SENSE = 0;
  localparam int ABSD_L2_IRQ_PRIO = 1;
  localparam int ABSD_L2_CONV_DATA1 = 2;
  localparam int ABSD_L2_DAC_DATA0 = 3;
  localparam int ABSD_L2_CNT_LD0 = 4;
  localparam int ABSD_L2_CNT_LD1 = 5;
  localparam int ABSD_L2_KNOB_RD = 6;
  localparam int ABSD_L2_CONV_REG0 = 7;

  // Reset values of strobe banks (all inactive high)
  localparam logic [3:0] ABSD_BANK_RST = 4'hf;
  localparam logic [7:0] ABSD_LOC_RST = 8'hff;

  // Counter load lines of the second decoder leave active high
  localparam logic [7:0] ABSD_LOC2_HIGH =
    8'(1 << ABSD_L2_CNT_LD0) | 8'(1 << ABSD_L2_CNT_LD1);
  localparam logic [7:0] ABSD_LOC2_RST = ABSD_LOC_RST ^ ABSD_LOC2_HIGH;

  typedef enum logic [1:0] {
    ABSD_IDLE,
    ABSD_DELAY,
    ABSD_STROBE
  } absd_state_t;

endpackage

// File: hdl/absd_dec_if.sv
// Select bundle between the strobe block and one of its demultiplexers.
// Assumes a purely combinational decoder on the dec side.
interface absd_dec_if #(parameter int W = 3);
  logic en;
  logic [W-1:0] sel;
  logic [(2**W)-1:0] line_n;

  modport dec (input en, input sel, output line_n);
  modport user (output en, output sel, input line_n);
endinterface

// File: hdl/absd_demux.sv
// Generic W-to-2**W active-low demultiplexer.
// Assumes the user registers the lines before they leave the chip.
module absd_demux #(
  parameter int W = 3
) (
  absd_dec_if.dec bus
);
  // One comparator per line, low only when enabled and addressed
  for (genvar i = 0; i < 2**W; i++) begin : g_line
    assign bus.line_n[i] = !(bus.en && (bus.sel == W'(i)));
  end
endmodule

// File: hdl/absd_strobe_top.sv
// Analog bus strobe timing and local select decoding.
// Assumes all inputs are synchronous to clk_in; the 1 MHz timing clock
// is sampled as a level and its rising edges are used as ticks.
module absd_strobe_top
  import absd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Timing and analog bus request
  input wire logic timing_clock_1mhz_in,
  input wire logic analog_bus_request_in,
  input wire logic [1:0] analog_unit_sel_in,
  // Local access enables and address
  input wire logic local_dec_one_en_in,
  input wire logic local_dec_two_en_in,
  input wire logic local_addr_bit0_in,
  input wire logic local_addr_bit1_in,
  input wire logic local_addr_bit2_in,
  input wire logic local_addr_bit3_in,
  // Analog bus strobes
  output logic rf_unit_strobe_n_out,
  output logic freq_ctrl_unit_strobe_n_out,
  output logic if_unit_strobe_n_out,
  output logic log_amp_unit_strobe_n_out,
  output logic freq_ctrl_strobe_qualifier_out,
  // First local decoder selects
  output logic keyboard_scan_sel_n_out,
  output logic dac_update_sel_n_out,
  output logic dac_one_sel_n_out,
  output logic dac_two_sel_n_out,
  output logic dac_three_sel_n_out,
  output logic timer_sel_n_out,
  output logic conv_reg_one_sel_n_out,
  // Second local decoder selects
  output logic keyboard_sense_sel_n_out,
  output logic irq_priority_sel_n_out,
  output logic conv_data_one_sel_n_out,
  output logic dac_data_zero_sel_n_out,
  output logic counter_load_zero_sel_out,
  output logic counter_load_one_sel_out,
  output logic knob_read_sel_n_out,
  output logic conv_reg_zero_sel_n_out
);

  absd_dec_if #(.W(2)) ana_dec ();
  absd_dec_if #(.W(3)) loc1_dec ();
  absd_dec_if #(.W(3)) loc2_dec ();

  absd_demux #(.W(2)) u_ana_demux (.bus(ana_dec));
  absd_demux #(.W(3)) u_loc1_demux (.bus(loc1_dec));
  absd_demux #(.W(3)) u_loc2_demux (.bus(loc2_dec));

  absd_state_t state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [1:0] unit_ff, nxt_unit;
  logic tclk_prev_ff, nxt_tclk_prev;
  logic req_prev_ff, nxt_req_prev;
  logic [3:0] bank_n_ff, nxt_bank_n;
  logic qual_ff, nxt_qual;
  logic [7:0] loc1_n_ff, nxt_loc1_n;
  logic [7:0] loc2_n_ff, nxt_loc2_n;
  logic tick;
  logic req_rise;

  assign tick = timing_clock_1mhz_in && !tclk_prev_ff;
  assign req_rise = analog_bus_request_in && !req_prev_ff;

  // Analog bus sequencing: wait for ticks, then strobe until request drops
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_unit = unit_ff;
    nxt_tclk_prev = timing_clock_1mhz_in;
    nxt_req_prev = analog_bus_request_in;
    case (state_ff)
      ABSD_IDLE: begin
        if (req_rise) begin
          nxt_state = ABSD_DELAY;
          nxt_cnt = ABSD_CNT_RST;
          nxt_unit = analog_unit_sel_in;
        end
      end
      ABSD_DELAY: begin
        if (!analog_bus_request_in) begin
          nxt_state = ABSD_IDLE;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 2'h1;
          if (cnt_ff + 2'h1 == ABSD_DELAY_TICKS) begin
            nxt_state = ABSD_STROBE;
          end
        end
      end
      ABSD_STROBE: begin
        if (!analog_bus_request_in) begin
          nxt_state = ABSD_IDLE;
        end
      end
      default: begin
        nxt_state = ABSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ABSD_IDLE;
      cnt_ff <= ABSD_CNT_RST;
      unit_ff <= ABSD_UNIT_RF;
      tclk_prev_ff <= 1'b0;
      req_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      unit_ff <= nxt_unit;
      tclk_prev_ff <= nxt_tclk_prev;
      req_prev_ff <= nxt_req_prev;
    end
  end

  // Strobe outputs, registered from the three demultiplexers
  assign ana_dec.en = (nxt_state == ABSD_STROBE);
  assign ana_dec.sel = nxt_unit;
  assign loc1_dec.en = local_dec_one_en_in;
  assign loc1_dec.sel = {local_addr_bit3_in, local_addr_bit2_in,
                         local_addr_bit1_in};
  assign loc2_dec.en = local_dec_two_en_in;
  assign loc2_dec.sel = {local_addr_bit2_in, local_addr_bit1_in,
                         local_addr_bit0_in};

  always_comb begin
    nxt_bank_n = ana_dec.line_n;
    nxt_qual = (nxt_state != ABSD_IDLE) && (nxt_unit == ABSD_UNIT_FC);
    nxt_loc1_n = loc1_dec.line_n;
    // Counter load bits are stored active high so outputs leave a flop
    nxt_loc2_n = loc2_dec.line_n ^ ABSD_LOC2_HIGH;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank_n_ff <= ABSD_BANK_RST;
      qual_ff <= 1'b0;
      loc1_n_ff <= ABSD_LOC_RST;
      loc2_n_ff <= ABSD_LOC2_RST;
    end else begin
      bank_n_ff <= nxt_bank_n;
      qual_ff <= nxt_qual;
      loc1_n_ff <= nxt_loc1_n;
      loc2_n_ff <= nxt_loc2_n;
    end
  end

  assign rf_unit_strobe_n_out = bank_n_ff[ABSD_UNIT_RF];
  assign freq_ctrl_unit_strobe_n_out = bank_n_ff[ABSD_UNIT_FC];
  assign if_unit_strobe_n_out = bank_n_ff[ABSD_UNIT_IF];
  assign log_amp_unit_strobe_n_out = bank_n_ff[ABSD_UNIT_LOG];
  assign freq_ctrl_strobe_qualifier_out = qual_ff;

  assign keyboard_scan_sel_n_out = loc1_n_ff[ABSD_L1_KBD_SCAN];
  assign dac_update_sel_n_out = loc1_n_ff[ABSD_L1_DAC_UPD];
  assign dac_one_sel_n_out = loc1_n_ff[ABSD_L1_DAC_ONE];
  assign dac_two_sel_n_out = loc1_n_ff[ABSD_L1_DAC_TWO];
  assign dac_three_sel_n_out = loc1_n_ff[ABSD_L1_DAC_THREE];
  assign timer_sel_n_out = loc1_n_ff[ABSD_L1_TIMER];
  assign conv_reg_one_sel_n_out = loc1_n_ff[ABSD_L1_CONV_REG1];

  // Counter load lines leave active high
  assign keyboard_sense_sel_n_out = loc2_n_ff[ABSD_L2_KBD_SENSE];
  assign irq_priority_sel_n_out = loc2_n_ff[ABSD_L2_IRQ_PRIO];
  assign conv_data_one_sel_n_out = loc2_n_ff[ABSD_L2_CONV_DATA1];
  assign dac_data_zero_sel_n_out = loc2_n_ff[ABSD_L2_DAC_DATA0];
  assign counter_load_zero_sel_out = loc2_n_ff[ABSD_L2_CNT_LD0];
  assign counter_load_one_sel_out = loc2_n_ff[ABSD_L2_CNT_LD1];
  assign knob_read_sel_n_out = loc2_n_ff[ABSD_L2_KNOB_RD];
  assign conv_reg_zero_sel_n_out = loc2_n_ff[ABSD_L2_CONV_REG0];

  // Checking helpers: ticks seen since the request rose
  logic [1:0] chk_ticks_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chk_ticks_ff <= 2'h0;
    end else if (req_rise && state_ff == ABSD_IDLE) begin
      chk_ticks_ff <= 2'h0;
    end else if (tick && chk_ticks_ff != 2'h3) begin
      chk_ticks_ff <= chk_ticks_ff + 2'h1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_last_tick;
    state_ff == ABSD_DELAY && analog_bus_request_in && tick
      && cnt_ff == 2'h1;
  endsequence

  sequence s_strobe_held;
    !(&bank_n_ff) [*2];
  endsequence

  chk_abus_delay_count: assert property (
    $fell(&bank_n_ff) |-> chk_ticks_ff == 2'h2)
    else $error("analog strobe fell before two timing ticks");

  chk_abus_strobe_due: assert property (
    s_last_tick |=> !(&bank_n_ff))
    else $error("analog strobe missing after second timing tick");

  chk_abus_one_hot: assert property (
    $countones(~bank_n_ff) <= 1)
    else $error("more than one analog strobe low");

  chk_fc_qualifier: assert property (
    !freq_ctrl_unit_strobe_n_out |-> freq_ctrl_strobe_qualifier_out)
    else $error("frequency control strobe without qualifier");

  chk_loc1_map: assert property (
    local_dec_one_en_in && !local_addr_bit1_in && local_addr_bit2_in
      && local_addr_bit3_in |=> !timer_sel_n_out
      && $countones(~loc1_n_ff) == 1)
    else $error("first decoder did not select the timer line");

  chk_loc2_map: assert property (
    local_dec_two_en_in && local_addr_bit0_in && local_addr_bit1_in
      && !local_addr_bit2_in |=> !dac_data_zero_sel_n_out
      && !counter_load_zero_sel_out && !counter_load_one_sel_out)
    else $error("second decoder did not select dac data zero");

  chk_loc_idle_high: assert property (
    !local_dec_one_en_in && !local_dec_two_en_in |=>
      &loc1_n_ff && loc2_n_ff == ABSD_LOC2_RST)
    else $error("local select low while decoder disabled");

  chk_abus_single_pulse: assert property (
    s_strobe_held ##1 $rose(&bank_n_ff) |-> !$past(analog_bus_request_in))
    else $error("analog strobe ended while request still high");

endmodule

// File: tb/absd_host_model.sv
// Behavioural model of the controller side of the analog bus.
// Assumes the bench calls its tasks from a process synced to clk_in.
module absd_host_model (
  // System clock
  input wire logic clk_in,
  // Timing clock and analog bus request
  output logic timing_clock_1mhz_out,
  output logic analog_bus_request_out,
  output logic [1:0] analog_unit_sel_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Free-running 1 MHz timing clock, unrelated in phase to clk_in
  initial begin
    timing_clock_1mhz_out = 1'b0;
    analog_bus_request_out = 1'b0;
    analog_unit_sel_out = 2'h0;
    #137;
    forever #500 timing_clock_1mhz_out = ~timing_clock_1mhz_out;
  end

  // Raise the request, then scramble the unit once it has been taken
  task automatic request(input logic [1:0] unit);
    @(posedge clk_in);
    #1;
    analog_unit_sel_out = unit;
    analog_bus_request_out = 1'b1;
    @(posedge clk_in);
    #1;
    analog_unit_sel_out = ~unit;
  endtask

  task automatic release_bus();
    @(posedge clk_in);
    #1;
    analog_bus_request_out = 1'b0;
  endtask
endmodule

// File: tb/analog_bus_strobe_decode_tb.sv
// Self-checking bench for the analog bus strobe decode block.
// Assumes a 100 MHz clk_in and the host model for the analog bus side.
module analog_bus_strobe_decode_tb
  import absd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in, rst_b_in, en1, en2, tclk, req;
  logic [3:0] addr;
  logic [1:0] usel;
  logic rf_n, fc_n, if_n, log_n, qual;
  logic [6:0] d1_n;
  logic [7:0] d2;
  int n_errors, num_checks;
  wire [3:0] ana_n = {log_n, if_n, fc_n, rf_n};

  absd_strobe_top u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .timing_clock_1mhz_in(tclk), .analog_bus_request_in(req),
    .analog_unit_sel_in(usel),
    .local_dec_one_en_in(en1), .local_dec_two_en_in(en2),
    .local_addr_bit0_in(addr[0]), .local_addr_bit1_in(addr[1]),
    .local_addr_bit2_in(addr[2]), .local_addr_bit3_in(addr[3]),
    .rf_unit_strobe_n_out(rf_n), .freq_ctrl_unit_strobe_n_out(fc_n),
    .if_unit_strobe_n_out(if_n), .log_amp_unit_strobe_n_out(log_n),
    .freq_ctrl_strobe_qualifier_out(qual),
    .keyboard_scan_sel_n_out(d1_n[0]), .dac_update_sel_n_out(d1_n[1]),
    .dac_one_sel_n_out(d1_n[2]), .dac_two_sel_n_out(d1_n[3]),
    .dac_three_sel_n_out(d1_n[4]), .timer_sel_n_out(d1_n[5]),
    .conv_reg_one_sel_n_out(d1_n[6]),
    .keyboard_sense_sel_n_out(d2[0]), .irq_priority_sel_n_out(d2[1]),
    .conv_data_one_sel_n_out(d2[2]), .dac_data_zero_sel_n_out(d2[3]),
    .counter_load_zero_sel_out(d2[4]), .counter_load_one_sel_out(d2[5]),
    .knob_read_sel_n_out(d2[6]), .conv_reg_zero_sel_n_out(d2[7])
  );

  absd_host_model u_host (
    .clk_in(clk_in), .timing_clock_1mhz_out(tclk),
    .analog_bus_request_out(req), .analog_unit_sel_out(usel)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One full access; strobe must land 1..2.15 us after the request edge
  task automatic analog_access(input logic [1:0] u);
    int cnt;
    u_host.request(u);
    tick(1);
    chk(8'(qual), 8'(u == ABSD_UNIT_FC));
    cnt = 2;
    while (ana_n === 4'hf && cnt < 400) begin
      tick(1);
      cnt++;
    end
    chk(8'(cnt >= 100 && cnt <= 215), 8'h01);
    chk({4'h0, ana_n}, {4'h0, ~(4'h1 << u)});
    chk(8'(qual), 8'(u == ABSD_UNIT_FC));
    u_host.release_bus();
    tick(2);
    chk(8'({qual, ana_n}), 8'h0f);
    if (cnt >= 400) tally_and_finish();
  endtask

  // Request dropped before the delay runs out gives no strobe
  task automatic analog_abort();
    logic bad;
    bad = 1'b0;
    u_host.request(ABSD_UNIT_IF);
    tick(50);
    u_host.release_bus();
    repeat (300) begin
      tick(1);
      if (ana_n !== 4'hf) bad = 1'b1;
    end
    chk(8'(bad), 8'h00);
  endtask

  task automatic local_one();
    logic [6:0] exp;
    for (int i = 0; i < 8; i++) begin
      en1 = 1'b1;
      addr = {3'(i), ~i[0]};
      tick(1);
      exp = (i == 5) ? 7'h7f : ~(7'h1 << ((i > 5) ? i - 1 : i));
      chk(8'(d1_n), 8'(exp));
      chk(d2, 8'hcf);
    end
    en1 = 1'b0;
    tick(1);
    chk(8'(d1_n), 8'h7f);
  endtask

  task automatic local_two();
    for (int i = 0; i < 8; i++) begin
      en2 = 1'b1;
      addr = {~i[0], 3'(i)};
      tick(1);
      chk(d2, ~(8'h01 << i) ^ 8'h30);
      chk(8'(d1_n), 8'h7f);
    end
    en2 = 1'b0;
    tick(1);
    chk(d2, 8'hcf);
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    rst_b_in = 1'b0;
    en1 = 1'b0;
    en2 = 1'b0;
    addr = 4'h0;
    repeat (6) @(posedge clk_in);
    #1;
    chk(8'({qual, ana_n}), 8'h0f);
    chk(8'(d1_n), 8'h7f);
    chk(d2, 8'hcf);
    rst_b_in = 1'b1;
    tick(1);
    for (int u = 0; u < 4; u++) analog_access(2'(u));
    analog_abort();
    local_one();
    local_two();
    tally_and_finish();
  end
endmodule
